// File: logic/pwm_setup_ctrl.v
// host controller that runs the modulator setup sequence over axi4-lite
`include "pwm_setup_regs.vh"
`timescale 1ns/100ps
module pwm_setup_ctrl
(
  input  wire        clk_sys,
  input  wire        rst_b,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp_r,
  output reg         s_axi_bvalid_r,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata_r,
  output reg  [1:0]  s_axi_rresp_r,
  output reg         s_axi_rvalid_r,
  input  wire        s_axi_rready,
  output wire        dev_req,
  output wire        dev_we,
  output wire [3:0]  dev_addr,
  output wire [7:0]  dev_wdata,
  input  wire        dev_ack,
  input  wire [7:0]  dev_rdata
);

  localparam S_IDLE  = 2'd0;
  localparam S_ISSUE = 2'd1;
  localparam S_WAIT  = 2'd2;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  reg  [31:0] cfg0_r;
  reg  [31:0] cfg1_r;
  reg  [31:0] cfg2_r;
  reg         aw_hold_r;
  reg  [7:0]  aw_addr_r;
  reg         w_hold_r;
  reg  [31:0] w_data_r;
  reg  [3:0]  w_strb_r;
  reg  [1:0]  state_r;
  reg  [4:0]  step_r;
  reg         go_r;
  reg         done_r;
  reg         ase_r;
  reg  [7:0]  last_rd_r;
  reg         start_cmd;
  reg         stat_cmd;

  wire        aw_fire;
  wire        w_fire;
  wire        aw_have;
  wire        w_have;
  wire        wr_do;
  wire [7:0]  wr_addr;
  wire [31:0] wr_data;
  wire [3:0]  wr_strb;
  wire [5:0]  wr_idx;
  wire [5:0]  rd_idx;
  wire        busy;
  wire        port_done;
  wire [7:0]  port_rdata;

  // ----------------------------------------------------------------
  // axi4-lite write path: address and data in either order
  // ----------------------------------------------------------------
  assign s_axi_awready = !aw_hold_r && !s_axi_bvalid_r;
  assign s_axi_wready  = !w_hold_r && !s_axi_bvalid_r;
  assign aw_fire = s_axi_awvalid && s_axi_awready;
  assign w_fire  = s_axi_wvalid && s_axi_wready;
  assign aw_have = aw_hold_r || aw_fire;
  assign w_have  = w_hold_r || w_fire;
  assign wr_do   = aw_have && w_have && !s_axi_bvalid_r;
  assign wr_addr = aw_hold_r ? aw_addr_r : s_axi_awaddr;
  assign wr_data = w_hold_r ? w_data_r : s_axi_wdata;
  assign wr_strb = w_hold_r ? w_strb_r : s_axi_wstrb;
  assign wr_idx  = wr_addr[7:2];

  // byte-lane merge of a write into a register
  function [31:0] merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0]  strb;
    input [31:0] mask;
    integer i;
    begin
      merge = old_v;
      for (i = 0; i < 4; i = i + 1)
        if (strb[i])
          merge[i*8 +: 8] = new_v[i*8 +: 8];
      merge = merge & mask;
    end
  endfunction

  // hold whichever half arrived first
  always @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      aw_hold_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_hold_r  <= 1'b0;
      w_data_r  <= 32'h00000000;
      w_strb_r  <= 4'h0;
    end
    else if (wr_do)
    begin
      aw_hold_r <= 1'b0;
      w_hold_r  <= 1'b0;
    end
    else
    begin
      if (aw_fire)
      begin
        aw_hold_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (w_fire)
      begin
        w_hold_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
    end
  end

  // register writes and write response
  always @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cfg0_r         <= `CFG0_RST;
      cfg1_r         <= `CFG1_RST;
      cfg2_r         <= `CFG2_RST;
      start_cmd      <= 1'b0;
      stat_cmd       <= 1'b0;
      s_axi_bvalid_r <= 1'b0;
      s_axi_bresp_r  <= `RESP_OKAY;
    end
    else
    begin
      start_cmd <= 1'b0;
      stat_cmd  <= 1'b0;
      if (s_axi_bvalid_r && s_axi_bready)
        s_axi_bvalid_r <= 1'b0;
      if (wr_do)
      begin
        s_axi_bvalid_r <= 1'b1;
        s_axi_bresp_r  <= `RESP_OKAY;
        case (wr_idx)
          `IDX_CMD:
          begin
            start_cmd <= wr_strb[0] && wr_data[`CMD_START];
            stat_cmd  <= wr_strb[0] && wr_data[`CMD_STATUS];
          end
          `IDX_CFG0: cfg0_r <= merge(cfg0_r, wr_data, wr_strb, `CFG0_MASK);
          `IDX_CFG1: cfg1_r <= merge(cfg1_r, wr_data, wr_strb, `CFG1_MASK);
          `IDX_CFG2: cfg2_r <= merge(cfg2_r, wr_data, wr_strb, `CFG2_MASK);
          `IDX_STAT: s_axi_bresp_r <= `RESP_OKAY;  // read only, ignored
          default:   s_axi_bresp_r <= `RESP_SLVERR;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite read path
  // ----------------------------------------------------------------
  assign s_axi_arready = !s_axi_rvalid_r;
  assign rd_idx = s_axi_araddr[7:2];

  always @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s_axi_rvalid_r <= 1'b0;
      s_axi_rdata_r  <= 32'h00000000;
      s_axi_rresp_r  <= `RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid_r <= 1'b1;
      s_axi_rresp_r  <= `RESP_OKAY;
      s_axi_rdata_r  <= 32'h00000000;
      case (rd_idx)
        `IDX_CMD:  s_axi_rdata_r <= 32'h00000000;
        `IDX_CFG0: s_axi_rdata_r <= cfg0_r;
        `IDX_CFG1: s_axi_rdata_r <= cfg1_r;
        `IDX_CFG2: s_axi_rdata_r <= cfg2_r;
        `IDX_STAT:
        begin
          s_axi_rdata_r[`STAT_BUSY]  <= busy;
          s_axi_rdata_r[`STAT_DONE]  <= done_r;
          s_axi_rdata_r[`STAT_ASE]   <= ase_r;
          s_axi_rdata_r[`STAT_RDATA] <= last_rd_r;
        end
        default:   s_axi_rresp_r <= `RESP_SLVERR;
      endcase
    end
    else if (s_axi_rvalid_r && s_axi_rready)
      s_axi_rvalid_r <= 1'b0;
  end

  // ----------------------------------------------------------------
  // setup step table: at most one device access per step (cmp, ansel and db steps can be skipped)
  // ----------------------------------------------------------------
  reg        op_we;
  reg  [3:0] op_addr;
  reg  [7:0] op_data;
  reg        op_skip;
  reg        op_last;
  wire [2:0] src;
  wire [7:0] asc_base;

  assign src      = cfg1_r[`CFG1_SRC];
  assign asc_base = {1'b0, src, cfg1_r[`CFG1_PSSAC], cfg1_r[`CFG1_PSSBD]};

  always @*
  begin
    op_we   = 1'b1;
    op_addr = `DEV_DIR;
    op_data = 8'hff;
    op_skip = 1'b0;
    op_last = 1'b0;
    case (step_r)
      `STEP_DIR_IN:
        op_data = 8'hff;
      `STEP_STEER:
      begin
        op_addr = `DEV_STEER;
        op_data = {3'b000, cfg1_r[`CFG1_SYNC], cfg1_r[`CFG1_STEER]};
      end
      `STEP_PERIOD:
      begin
        op_addr = `DEV_PERIOD;
        op_data = cfg0_r[`CFG0_PERIOD];
      end
      `STEP_SRC:
      begin
        op_addr = `DEV_ASC;
        op_data = asc_base;
      end
      `STEP_CMP:
      begin
        op_addr = `DEV_CMP;
        op_data = cfg2_r[`CFG2_CMP];
        op_skip = (cfg1_r[`CFG1_SRC_CMP] == 2'b00);
      end
      `STEP_ANSEL:
      begin
        op_addr = `DEV_ANSEL;
        op_data = cfg2_r[`CFG2_ANSEL];
        op_data[`FAULT_ANSEL] = 1'b0;
        op_skip = !cfg1_r[`CFG1_SRC_FLT];
      end
      `STEP_PSS:
      begin
        op_addr = `DEV_ASC;
        op_data = asc_base;
      end
      `STEP_NORST:
      begin
        op_addr = `DEV_RDC;
        op_data = {1'b0, cfg1_r[`CFG1_DB]};
      end
      `STEP_FORCE:
      begin
        op_addr = `DEV_ASC;
        op_data = asc_base;
        op_data[`ASC_ASE] = 1'b1;
      end
      `STEP_CHAN:
      begin
        op_addr = `DEV_CHAN;
        op_data = {cfg0_r[`CFG0_OUTCFG], cfg0_r[`CFG0_DUTY_LO],
                   cfg0_r[`CFG0_MODE]};
      end
      `STEP_DUTYH:
      begin
        op_addr = `DEV_DUTYH;
        op_data = cfg0_r[`CFG0_DUTY_HI];
      end
      `STEP_DB:
      begin
        op_addr = `DEV_RDC;
        op_data = {1'b0, cfg1_r[`CFG1_DB]};
        op_skip = (cfg0_r[`CFG0_OUTCFG] != `HALF_BRIDGE);
      end
      `STEP_PRESC:
      begin
        op_addr = `DEV_TCTL;
        op_data = {6'b000000, cfg0_r[`CFG0_PRESC]};
      end
      `STEP_RUN:
      begin
        op_addr = `DEV_TCTL;
        op_data = {6'b000000, cfg0_r[`CFG0_PRESC]};
        op_data[`TCTL_RUN] = 1'b1;
      end
      `STEP_DIR_OUT:
        op_data = {`DIR_UNUSED, ~cfg1_r[`CFG1_STEER]};
      `STEP_GO:
      begin
        op_last = 1'b1;
        if (cfg1_r[`CFG1_RSEN])
        begin
          op_addr = `DEV_RDC;
          op_data = {1'b1, cfg1_r[`CFG1_DB]};
        end
        else
        begin
          op_addr = `DEV_ASC;
          op_data = asc_base;
        end
      end
      `STEP_READ:
      begin
        op_we   = 1'b0;
        op_addr = `DEV_ASC;
        op_data = 8'h00;
        op_last = 1'b1;
      end
      default:
      begin
        op_skip = 1'b1;
        op_last = 1'b1;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // sequencer: walks the table in order, one access at a time
  // ----------------------------------------------------------------
  assign busy = (state_r != S_IDLE);

  always @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_r   <= S_IDLE;
      step_r    <= `STEP_DIR_IN;
      go_r      <= 1'b0;
      done_r    <= 1'b0;
      ase_r     <= 1'b0;
      last_rd_r <= 8'h00;
    end
    else
    begin
      go_r <= 1'b0;
      case (state_r)
        S_IDLE:
        begin
          if (start_cmd)
          begin
            done_r  <= 1'b0;
            step_r  <= `STEP_DIR_IN;
            state_r <= S_ISSUE;
          end
          else if (stat_cmd)
          begin
            step_r  <= `STEP_READ;
            state_r <= S_ISSUE;
          end
        end
        S_ISSUE:
        begin
          if (op_skip && op_last)
          begin
            done_r  <= 1'b1;
            state_r <= S_IDLE;
          end
          else if (op_skip)
            step_r <= step_r + `STEP_INC;
          else
          begin
            go_r    <= 1'b1;
            state_r <= S_WAIT;
          end
        end
        S_WAIT:
        begin
          if (port_done)
          begin
            if (!op_we)
            begin
              last_rd_r <= port_rdata;
              ase_r     <= port_rdata[`ASC_ASE];
            end
            if (op_last)
            begin
              done_r  <= 1'b1;
              state_r <= S_IDLE;
            end
            else
            begin
              step_r  <= step_r + `STEP_INC;
              state_r <= S_ISSUE;
            end
          end
        end
        default:
          state_r <= S_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // device register port
  // ----------------------------------------------------------------
  dev_reg_port u_port
  (
    .clk_sys     (clk_sys),
    .rst_b       (rst_b),
    .go          (go_r),
    .we          (op_we),
    .addr        (op_addr),
    .wdata       (op_data),
    .done        (port_done),
    .rdata_r     (port_rdata),
    .dev_req_r   (dev_req),
    .dev_we_r    (dev_we),
    .dev_addr_r  (dev_addr),
    .dev_wdata_r (dev_wdata),
    .dev_ack     (dev_ack),
    .dev_rdata   (dev_rdata)
  );

endmodule

// File: logic/pwm_setup_regs.vh
// constants for the modulator setup controller and the device it drives
`ifndef PWM_SETUP_REGS_VH
`define PWM_SETUP_REGS_VH

// ----------------------------------------------------------------
// own register word indices (byte address = index * 4)
// ----------------------------------------------------------------
`define IDX_CMD        6'h00
`define IDX_CFG0       6'h01
`define IDX_CFG1       6'h02
`define IDX_CFG2       6'h03
`define IDX_STAT       6'h04

// command bits, self clearing
`define CMD_START      0
`define CMD_STATUS     1

// cfg0 fields
`define CFG0_PERIOD    7:0
`define CFG0_DUTY      17:8
`define CFG0_DUTY_HI   17:10
`define CFG0_DUTY_LO   9:8
`define CFG0_PRESC     19:18
`define CFG0_OUTCFG    21:20
`define CFG0_MODE      25:22
`define CFG0_RST       32'h030000ff
`define CFG0_MASK      32'h03ffffff

// cfg1 fields
`define CFG1_STEER     3:0
`define CFG1_SYNC      4
`define CFG1_SRC       7:5
`define CFG1_SRC_CMP   6:5
`define CFG1_SRC_FLT   7
`define CFG1_PSSAC     9:8
`define CFG1_PSSBD     11:10
`define CFG1_RSEN      12
`define CFG1_DB        19:13
`define CFG1_RST       32'h00000000
`define CFG1_MASK      32'h000fffff

// cfg2 fields
`define CFG2_CMP       7:0
`define CFG2_ANSEL     15:8
`define CFG2_RST       32'h00000000
`define CFG2_MASK      32'h0000ffff

// status fields
`define STAT_BUSY      0
`define STAT_DONE      1
`define STAT_ASE       2
`define STAT_RDATA     15:8

// bus responses
`define RESP_OKAY      2'b00
`define RESP_SLVERR    2'b10

// ----------------------------------------------------------------
// device register map, as seen through its register port
// ----------------------------------------------------------------
`define DEV_ASC        4'h0
`define DEV_CHAN       4'h1
`define DEV_TSEL       4'h2
`define DEV_PERIOD     4'h3
`define DEV_STEER      4'h4
`define DEV_RDC        4'h5
`define DEV_TCTL       4'h6
`define DEV_TCNT       4'h7
`define DEV_DUTYH      4'h8
`define DEV_DIR        4'h9
`define DEV_CMP        4'ha
`define DEV_ANSEL      4'hb

// device field positions and codes
`define ASC_ASE        7
`define RDC_RSEN       7
`define TCTL_RUN       2
`define FAULT_ANSEL    0
`define HALF_BRIDGE    2'b10
`define DIR_UNUSED     4'hf

// ----------------------------------------------------------------
// sequencer steps
// ----------------------------------------------------------------
`define STEP_DIR_IN    5'h00
`define STEP_STEER     5'h01
`define STEP_PERIOD    5'h02
`define STEP_SRC       5'h03
`define STEP_CMP       5'h04
`define STEP_ANSEL     5'h05
`define STEP_PSS       5'h06
`define STEP_NORST     5'h07
`define STEP_FORCE     5'h08
`define STEP_CHAN      5'h09
`define STEP_DUTYH     5'h0a
`define STEP_DB        5'h0b
`define STEP_PRESC     5'h0c
`define STEP_RUN       5'h0d
`define STEP_DIR_OUT   5'h0e
`define STEP_GO        5'h0f
`define STEP_READ      5'h10
`define STEP_INC       5'h01

`endif

// File: logic/dev_reg_port.v
// four-phase request/acknowledge access port to the device registers
`timescale 1ns/100ps
module dev_reg_port
(
  input  wire       clk_sys,
  input  wire       rst_b,
  input  wire       go,
  input  wire       we,
  input  wire [3:0] addr,
  input  wire [7:0] wdata,
  output wire       done,
  output reg  [7:0] rdata_r,
  output reg        dev_req_r,
  output reg        dev_we_r,
  output reg  [3:0] dev_addr_r,
  output reg  [7:0] dev_wdata_r,
  input  wire       dev_ack,
  input  wire [7:0] dev_rdata
);

  localparam ST_IDLE = 2'd0;
  localparam ST_REQ  = 2'd1;
  localparam ST_REL  = 2'd2;

  reg  [1:0] state_r;
  reg        ack_s1_r;
  reg        ack_s2_r;
  reg  [7:0] rd_s1_r;
  reg  [7:0] rd_s2_r;
  reg        done_r;

  assign done = done_r;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  always @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ack_s1_r <= 1'b0;
      ack_s2_r <= 1'b0;
      rd_s1_r  <= 8'h00;
      rd_s2_r  <= 8'h00;
    end
    else
    begin
      ack_s1_r <= dev_ack;
      ack_s2_r <= ack_s1_r;
      rd_s1_r  <= dev_rdata;
      rd_s2_r  <= rd_s1_r;
    end
  end

  // ----------------------------------------------------------------
  // handshake: raise req, wait ack, drop req, wait ack low
  // ----------------------------------------------------------------
  always @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_r     <= ST_IDLE;
      dev_req_r   <= 1'b0;
      dev_we_r    <= 1'b0;
      dev_addr_r  <= 4'h0;
      dev_wdata_r <= 8'h00;
      rdata_r     <= 8'h00;
      done_r      <= 1'b0;
    end
    else
    begin
      done_r <= 1'b0;
      case (state_r)
        ST_IDLE:
        begin
          if (go)
          begin
            dev_we_r    <= we;
            dev_addr_r  <= addr;
            dev_wdata_r <= wdata;
            dev_req_r   <= 1'b1;
            state_r     <= ST_REQ;
          end
        end
        ST_REQ:
        begin
          if (ack_s2_r)
          begin
            rdata_r   <= rd_s2_r;  // device holds data while ack high
            dev_req_r <= 1'b0;
            state_r   <= ST_REL;
          end
        end
        ST_REL:
        begin
          if (!ack_s2_r)
          begin
            done_r  <= 1'b1;
            state_r <= ST_IDLE;
          end
        end
        default:
        begin
          dev_req_r <= 1'b0;
          state_r   <= ST_IDLE;
        end
      endcase
    end
  end

endmodule

// File: tb/pwm_setup_ctrl_monitor.sv
// protocol checker for the modulator setup controller ports
`timescale 1ns/100ps
`include "pwm_setup_regs.vh"
module pwm_setup_ctrl_monitor
(
  input wire       clk_sys,
  input wire       rst_b,
  input wire [7:0] s_axi_awaddr,
  input wire       s_axi_awvalid,
  input wire       s_axi_awready,
  input wire       s_axi_wvalid,
  input wire       s_axi_wready,
  input wire [1:0] s_axi_bresp_r,
  input wire       s_axi_bvalid_r,
  input wire       s_axi_bready,
  input wire       s_axi_arvalid,
  input wire       s_axi_arready,
  input wire       s_axi_rvalid_r,
  input wire       s_axi_rready,
  input wire       dev_req,
  input wire [3:0] dev_addr,
  input wire [7:0] dev_wdata,
  input wire       dev_ack
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  // both write halves taken on one edge
  sequence s_wr_both;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // device has answered a standing request
  sequence s_dev_acked;
    dev_req && dev_ack;
  endsequence

  a_wr_okay: assert property (s_wr_both ##0 s_axi_awaddr[7:2] <= 6'h04
    |=> s_axi_bvalid_r && s_axi_bresp_r == `RESP_OKAY)
    else $error("mapped write not answered okay next cycle");
  a_wr_unmapped: assert property (s_wr_both ##0 s_axi_awaddr[7:2] > 6'h04
    |=> s_axi_bvalid_r && s_axi_bresp_r == `RESP_SLVERR)
    else $error("unmapped write not refused next cycle");
  a_bresp_hold: assert property (s_axi_bvalid_r && !s_axi_bready
    |=> s_axi_bvalid_r && $stable(s_axi_bresp_r))
    else $error("write response dropped before bready");
  a_b_blocks: assert property (s_axi_bvalid_r
    |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid_r ##0 !s_axi_arready)
    else $error("read not answered next cycle");
  a_rvalid_hold: assert property (s_axi_rvalid_r && !s_axi_rready
    |=> s_axi_rvalid_r)
    else $error("read data dropped before rready");
  a_req_hold: assert property (dev_req && !dev_ack
    |=> dev_req && $stable(dev_addr) && $stable(dev_wdata))
    else $error("device request changed before answer");
  a_req_release: assert property (s_dev_acked |-> ##[1:4] !dev_req)
    else $error("device request held after answer");
  a_req_gap: assert property ($fell(dev_req) |-> !dev_req [*3])
    else $error("device requests too close together");
endmodule

// File: tb/pwm_dev_model.sv
// behavioural model of the modulator device behind its register port
`timescale 1ns/100ps
`include "pwm_setup_regs.vh"
module pwm_dev_model
(
  input  wire       clk_sys,
  input  wire       rst_b,
  input  wire       slow,
  input  wire       fault,
  input  wire       dev_req,
  input  wire       dev_we,
  input  wire [3:0] dev_addr,
  input  wire [7:0] dev_wdata,
  output reg        dev_ack,
  output wire [7:0] dev_rdata
);
  reg [7:0] regs [0:15];
  reg [7:0] rd_r;
  reg [3:0] wait_r;
  reg [3:0] log_a [0:63];
  reg [7:0] log_d [0:63];
  integer   log_n;
  integer   i;

  // read byte valid only while answering, else inverted
  assign dev_rdata = dev_ack ? rd_r : ~rd_r;

  // register file, shutdown status and four-phase answer
  always @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      dev_ack <= 1'b0;
      wait_r <= 4'h0;
      rd_r <= 8'h00;
      log_n <= 0;
      for (i = 0; i < 16; i = i + 1)
        regs[i] <= 8'h00;
    end
    else
    begin
      if (fault)
        regs[`DEV_ASC][`ASC_ASE] <= 1'b1;
      else if (regs[`DEV_RDC][`RDC_RSEN])
        regs[`DEV_ASC][`ASC_ASE] <= 1'b0;
      if (!dev_req)
      begin
        dev_ack <= 1'b0;
        wait_r <= 4'h0;
      end
      else if (!dev_ack && wait_r != (slow ? 4'h6 : 4'h0))
        wait_r <= wait_r + 4'h1;
      else if (!dev_ack)
      begin
        dev_ack <= 1'b1;
        rd_r <= regs[dev_addr];
        if (dev_we)
        begin
          log_a[log_n] <= dev_addr;
          log_d[log_n] <= dev_wdata;
          log_n <= log_n + 1;
          // status write keeps the ASE bit set while the fault persists
          regs[dev_addr] <= (fault && dev_addr == `DEV_ASC) ?
                            (dev_wdata | 8'h80) : dev_wdata;
        end
      end
    end
  end
endmodule

// File: tb/pwm_setup_ctrl_tb.sv
// self-checking bench for the modulator setup controller
`timescale 1ns/100ps
`include "pwm_setup_regs.vh"
module pwm_setup_ctrl_tb;
  reg  [7:0]  awaddr = 8'h00, araddr = 8'h00;
  reg  [31:0] wdata = 32'h0, rv, c0, c1, c2;
  reg  [3:0]  wstrb = 4'h0;
  reg         clk_sys = 1'b0, rst_b = 1'b0, slow = 1'b0, fault = 1'b0;
  reg         awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  reg         arvalid = 1'b0, rready = 1'b0;
  reg  [1:0]  rr;
  reg  [11:0] want [0:31];
  wire        awready, wready, bvalid, arready, rvalid, dreq, dwe, dack;
  wire [1:0]  bresp, rresp;
  wire [31:0] rdata;
  wire [3:0]  daddr;
  wire [7:0]  dwd, drd;
  integer     checks = 0, miscompares = 0, cyc = 0, base, k, n, ne;

  // 20 MHz system clock
  always #25 clk_sys = ~clk_sys;

  pwm_setup_ctrl dut
  (
    .clk_sys(clk_sys), .rst_b(rst_b), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp_r(bresp), .s_axi_bvalid_r(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata_r(rdata), .s_axi_rresp_r(rresp),
    .s_axi_rvalid_r(rvalid), .s_axi_rready(rready), .dev_req(dreq),
    .dev_we(dwe), .dev_addr(daddr), .dev_wdata(dwd), .dev_ack(dack),
    .dev_rdata(drd)
  );

  pwm_dev_model dev
  (
    .clk_sys(clk_sys), .rst_b(rst_b), .slow(slow), .fault(fault),
    .dev_req(dreq), .dev_we(dwe), .dev_addr(daddr), .dev_wdata(dwd),
    .dev_ack(dack), .dev_rdata(drd)
  );

  // ----------------------------------------------------------------
  // bus and checking tasks
  // ----------------------------------------------------------------
  task chk(input string nm, input [31:0] seen, input [31:0] ex);
    begin
      checks = checks + 1;
      if (seen !== ex)
      begin
        miscompares = miscompares + 1;
        $display("[ERR] %0s exp %h seen %h", nm, ex, seen);
      end
    end
  endtask

  task wr(input [7:0] a, input [31:0] d, input [3:0] s, input [1:0] er);
    reg ta, tw, tb;
    begin
      @(posedge clk_sys);
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      tb = 1'b0;
      while (!tb)
      begin
        @(negedge clk_sys);
        ta = awvalid && awready;
        tw = wvalid && wready;
        tb = bvalid;
        rr = bresp;
        @(posedge clk_sys);
        if (ta)
          awvalid <= 1'b0;
        if (tw)
          wvalid <= 1'b0;
        if (tb)
          bready <= 1'b0;
      end
      chk("bresp", {30'h0, rr}, {30'h0, er});
    end
  endtask

  task rd(input [7:0] a);
    reg ta, tr;
    begin
      @(posedge clk_sys);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      tr = 1'b0;
      while (!tr)
      begin
        @(negedge clk_sys);
        ta = arvalid && arready;
        tr = rvalid;
        rv = rdata;
        rr = rresp;
        @(posedge clk_sys);
        if (ta)
          arvalid <= 1'b0;
        if (tr)
          rready <= 1'b0;
      end
    end
  endtask

  // issue a command and poll status until idle and done
  task run(input [1:0] cmd);
    begin
      wr(8'h00, {30'h0, cmd}, 4'hf, `RESP_OKAY);
      n = 0;
      rv = 32'h0;
      while (rv[`STAT_DONE:`STAT_BUSY] !== 2'b10 && n < 300)
      begin
        rd(8'h10);
        n = n + 1;
      end
      chk("done", {31'h0, rv[`STAT_DONE]}, 32'h1);
    end
  endtask

  task push(input [3:0] a, input [7:0] d);
    begin
      want[ne] = {a, d};
      ne = ne + 1;
    end
  endtask

  // configure, start, then compare the device write sequence
  task go(input [31:0] a, input [31:0] b, input [31:0] c, input s);
    reg [7:0] asc;
    begin
      c0 = a;
      c1 = b;
      c2 = c;
      slow <= s;
      wr(8'h04, a, 4'hf, `RESP_OKAY);
      wr(8'h08, b, 4'hf, `RESP_OKAY);
      wr(8'h0c, c, 4'hf, `RESP_OKAY);
      ne = 0;
      asc = {1'b0, c1[7:5], c1[9:8], c1[11:10]};
      push(`DEV_DIR, 8'hff);
      push(`DEV_STEER, {3'h0, c1[4:0]});
      push(`DEV_PERIOD, c0[7:0]);
      push(`DEV_ASC, asc);
      if (c1[6:5] != 2'h0)
        push(`DEV_CMP, c2[7:0]);
      if (c1[7])
        push(`DEV_ANSEL, c2[15:8] & 8'hfe);
      push(`DEV_ASC, asc);
      push(`DEV_RDC, {1'b0, c1[19:13]});
      push(`DEV_ASC, asc | 8'h80);
      push(`DEV_CHAN, {c0[21:20], c0[9:8], c0[25:22]});
      push(`DEV_DUTYH, c0[17:10]);
      if (c0[21:20] == `HALF_BRIDGE)
        push(`DEV_RDC, {1'b0, c1[19:13]});
      push(`DEV_TCTL, {6'h0, c0[19:18]});
      push(`DEV_TCTL, {5'h0, 1'b1, c0[19:18]});
      push(`DEV_DIR, {4'hf, ~c1[3:0]});
      if (c1[12])
        push(`DEV_RDC, {1'b1, c1[19:13]});
      else
        push(`DEV_ASC, asc);
      base = dev.log_n;
      run(2'h1);
      chk("steps", dev.log_n - base, ne);
      for (k = 0; k < ne; k = k + 1)
        chk("access", {dev.log_a[base+k], dev.log_d[base+k]}, want[k]);
    end
  endtask

  task final_report;
    begin
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask

  // cycle ceiling against a hung handshake
  always @(posedge clk_sys)
  begin
    cyc = cyc + 1;
    if (cyc == 30000)
    begin
      miscompares = miscompares + 1;
      final_report;
    end
  end

  // main sequence
  initial
  begin
    repeat (10) @(posedge clk_sys);
    rst_b <= 1'b1;
    for (k = 0; k < 5; k = k + 1)
    begin
      rd(k * 4);
      chk("reset", rv, (k == 1) ? `CFG0_RST : 32'h0);
    end
    rd(8'h40);
    chk("rd_bad", {rr, rv[29:0]}, {`RESP_SLVERR, 30'h0});
    wr(8'h44, 32'hffffffff, 4'hf, `RESP_SLVERR);
    wr(8'h10, 32'hffffffff, 4'hf, `RESP_OKAY);
    rd(8'h10);
    chk("stat_ro", rv, 32'h0);
    wr(8'h0c, 32'hffffffff, 4'h1, `RESP_OKAY);
    rd(8'h0c);
    chk("strobe", rv, 32'h000000ff);
    wr(8'h04, 32'hffffffff, 4'hf, `RESP_OKAY);
    rd(8'h04);
    chk("mask", rv, `CFG0_MASK);
    go({6'h0, 4'hd, 2'b10, 2'b01, 10'h2c7, 8'h80},
       {12'h0, 7'h15, 1'b0, 2'b10, 2'b01, 3'b101, 1'b1, 4'h3},
       {16'h0, 8'h0f, 8'h5a}, 1'b0);
    go({6'h0, 4'hf, 2'b01, 2'b10, 10'h001, 8'h00},
       {12'h0, 7'h00, 1'b0, 2'b01, 2'b00, 3'b010, 1'b0, 4'h9},
       {16'h0, 8'hff, 8'ha5}, 1'b1);
    go({6'h0, 4'hc, 2'b00, 2'b11, 10'h3ff, 8'hff},
       {12'h0, 7'h7f, 1'b1, 2'b00, 2'b11, 3'b000, 1'b0, 4'hf},
       {16'h0, 8'h00, 8'h00}, 1'b1);
    fault <= 1'b1;
    run(2'h2);
    chk("ase_set", {rv[`STAT_ASE], rv[15:8]}, {1'b1, 8'h8c});
    fault <= 1'b0;
    repeat (2) @(posedge clk_sys);
    run(2'h2);
    chk("ase_clr", {rv[`STAT_ASE], rv[15:8]}, {1'b0, 8'h0c});
    final_report;
  end
endmodule

bind pwm_setup_ctrl pwm_setup_ctrl_monitor mon
(
  .clk_sys(clk_sys), .rst_b(rst_b), .s_axi_awaddr(s_axi_awaddr),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp_r(s_axi_bresp_r), .s_axi_bvalid_r(s_axi_bvalid_r),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid_r(s_axi_rvalid_r),
  .s_axi_rready(s_axi_rready), .dev_req(dev_req), .dev_addr(dev_addr),
  .dev_wdata(dev_wdata), .dev_ack(dev_ack)
);
